// >>> logic/vss_pkg.sv
package vss_pkg;
    // top-level state of the sequencer
    typedef enum logic [1:0] {
        VSS_SHUT,
        VSS_SOFT,
        VSS_RUN
    } vss_state_t;

    // apb register byte offsets
    localparam logic [11:0] VSS_CTRL_OFS = 12'h000;
    localparam logic [11:0] VSS_STATUS_OFS = 12'h004;
    localparam logic [11:0] VSS_CODE_OFS = 12'h008;
    localparam logic [11:0] VSS_SSCNT_OFS = 12'h00c;
    localparam logic [11:0] VSS_LEVEL_OFS = 12'h010;

    // ctrl field positions and reset value
    localparam int VSS_CTRL_SOFT_EN_BIT = 0;
    localparam logic [31:0] VSS_CTRL_RESET = 32'h0000_0001;

    // status field positions
    localparam int VSS_ST_STATE_LSB = 0;
    localparam int VSS_ST_POWER_GOOD_FLAG_BIT = 2;
    localparam int VSS_ST_PEND_BIT = 3;
    localparam int VSS_ST_OSC_BIT = 4;

    // code register field positions
    localparam int VSS_CD_REF_LSB = 0;
    localparam int VSS_CD_GOAL_LSB = 8;
    localparam int VSS_CD_PEND_LSB = 16;
    localparam int VSS_CD_SAMP_LSB = 24;

    // level register field positions
    localparam int VSS_LV_TARGET_LSB = 0;
    localparam int VSS_LV_IRAMP_LSB = 16;

    // identification code and reference scale
    localparam int VSS_CODE_W = 5;
    localparam logic [4:0] VSS_CODE_RSV = 5'h1f;
    localparam logic [4:0] VSS_CODE_RESET = 5'h1f;
    localparam int VSS_REF_TOP_STEPS = 62;
    localparam int VSS_STEP_MV = 25;
    localparam int VSS_MV_W = 12;

    // soft-start timing and ramp shape
    localparam int VSS_SS_W = 11;
    localparam int VSS_SS_CYCLES = 2048;
    localparam logic [10:0] VSS_SS_LAST = 11'h7ff;
    localparam int VSS_RAMP_PCT = 140;
    localparam int VSS_IRAMP_UA = 160;
    localparam int VSS_IRAMP_W = 8;

    // pin synchroniser depth
    localparam int VSS_SYNC_STAGES = 2;
endpackage

// >>> logic/vss_sync.sv
`timescale 1ns/1ns
module vss_sync
    import vss_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } vss_sync_st_t;

    vss_sync_st_t st_r;
    vss_sync_st_t st_nxt;

    // stage one feeds only stage two, so metastability never reaches logic
    always_comb
    begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2;
endmodule

// >>> logic/vss_ref_math.sv
`timescale 1ns/1ns
module vss_ref_math
    import vss_pkg::*;
(
    input wire logic [4:0] ref_code,
    input wire logic [10:0] ss_cnt,
    input wire vss_pkg::vss_state_t state,
    output logic [11:0] ref_mv,
    output logic [11:0] ramp_mv,
    output logic [7:0] iramp_ua,
    output logic [11:0] target_mv
);
    logic [31:0] ref_w;
    logic [31:0] ramp_w;
    logic [31:0] iramp_w;

    // reference, ramp and offset current; pure combinational, registered above
    always_comb
    begin
        ref_w = (32'(VSS_REF_TOP_STEPS) - 32'(ref_code)) * 32'(VSS_STEP_MV);
        ramp_w = ref_w;
        iramp_w = 32'd0;
        if (state == VSS_SOFT)
        begin
            // linear ramp to 140 percent over the counter span
            ramp_w = (ref_w * 32'(VSS_RAMP_PCT) * 32'(ss_cnt))
                / (32'd100 * 32'(VSS_SS_CYCLES));
            iramp_w = (32'(VSS_IRAMP_UA) * (32'(VSS_SS_CYCLES) - 32'(ss_cnt)))
                / 32'(VSS_SS_CYCLES);
        end
        else if (state == VSS_RUN)
            ramp_w = (ref_w * 32'(VSS_RAMP_PCT)) / 32'd100;
        ref_mv = ref_w[11:0];
        ramp_mv = ramp_w[11:0];
        iramp_ua = iramp_w[7:0];
        // the lower of ramp and reference is regulated during soft-start
        target_mv = (state == VSS_SOFT && ramp_w < ref_w) ? ramp_w[11:0] : ref_w[11:0];
    end
endmodule

// >>> logic/vss_sequencer.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module vss_sequencer
    import vss_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic por_ok,
    input wire logic enable_cmp,
    input wire logic freq_select_disable,
    input wire logic phase_clk,
    input wire logic [4:0] voltage_id_code,
    input wire logic out_in_window,
    input wire logic [1:0] pwm_mod,
    output logic [1:0] pwm_out,
    output logic [1:0] pwm_oe,
    output logic power_good_flag_out,
    output logic power_good_flag_oe,
    output logic osc_run,
    output logic [4:0] ref_code,
    output logic [11:0] target_mv,
    output logic [11:0] ramp_mv,
    output logic [7:0] iramp_ua
);
    import vss_pkg::*;

    typedef struct packed {
        vss_state_t state;
        logic ph_prev;
        logic [4:0] samp;
        logic [4:0] pend;
        logic pend_v;
        logic [4:0] goal;
        logic [4:0] refc;
        logic step_ph;
        logic [10:0] ss_cnt;
        logic soft_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] pwm_out;
        logic [1:0] pwm_oe;
        logic pg_oe;
        logic osc_run;
        logic [11:0] target_mv;
        logic [11:0] ramp_mv;
        logic [7:0] iramp_ua;
    } vss_seq_st_t;

    vss_seq_st_t st_r;
    vss_seq_st_t st_nxt;

    logic [4:0] code_s;
    logic [1:0] pwm_s;
    logic [4:0] lvl_s;
    logic por_s;
    logic en_s;
    logic dis_n_s;
    logic ph_s;
    logic win_s;
    logic pulse;
    logic start_ok;
    logic [11:0] m_ref;
    logic [11:0] m_ramp;
    logic [7:0] m_iramp;
    logic [11:0] m_target;

    // all pins pass two flops; comparator levels arrive already with hysteresis
    vss_sync #(.WIDTH(12)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({voltage_id_code, pwm_mod, por_ok, enable_cmp, freq_select_disable,
            phase_clk, out_in_window}),
        .q({code_s, pwm_s, lvl_s})
    );
    assign por_s = lvl_s[4];
    assign en_s = lvl_s[3];
    assign dis_n_s = lvl_s[2];
    assign ph_s = lvl_s[1];
    assign win_s = lvl_s[0];

    // rising edge of the phase clock marks the start of a channel-one cycle
    assign pulse = ph_s & ~st_r.ph_prev;

    // every start condition together; bias gates enable first
    assign start_ok = por_s & en_s & dis_n_s & st_r.soft_en & (st_r.samp != VSS_CODE_RSV);

    // levels for the state that is being entered, registered below
    vss_ref_math u_math (
        .ref_code(st_nxt.refc),
        .ss_cnt(st_nxt.ss_cnt),
        .state(st_nxt.state),
        .ref_mv(m_ref),
        .ramp_mv(m_ramp),
        .iramp_ua(m_iramp),
        .target_mv(m_target)
    );

    // sequencing, code validation, stepping and the apb slave
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.ph_prev = ph_s;
        if (pulse)
            st_nxt.samp = code_s;
        unique case (st_r.state)
            VSS_SHUT:
            begin
                if (start_ok)
                begin
                    st_nxt.state = VSS_SOFT;
                    st_nxt.ss_cnt = '0;
                    st_nxt.goal = st_r.samp;
                    st_nxt.refc = st_r.samp;
                    st_nxt.pend_v = 1'b0;
                    st_nxt.step_ph = 1'b0;
                end
            end
            VSS_SOFT, VSS_RUN:
            begin
                if (!start_ok || (pulse && code_s == VSS_CODE_RSV))
                    st_nxt.state = VSS_SHUT;
                else if (pulse)
                begin
                    if (st_r.state == VSS_SOFT)
                    begin
                        st_nxt.ss_cnt = st_r.ss_cnt + 11'h001;
                        if (st_r.ss_cnt == VSS_SS_LAST)
                            st_nxt.state = VSS_RUN;
                    end
                    // a new code waits one whole cycle before it is believed
                    if (st_r.pend_v)
                    begin
                        if (code_s == st_r.pend)
                        begin
                            st_nxt.goal = st_r.pend;
                            st_nxt.pend_v = 1'b0;
                            st_nxt.step_ph = 1'b0;
                        end
                        else if (code_s == st_r.goal)
                            st_nxt.pend_v = 1'b0;
                        else
                            st_nxt.pend = code_s;
                    end
                    else if (code_s != st_r.goal)
                    begin
                        st_nxt.pend = code_s;
                        st_nxt.pend_v = 1'b1;
                    end
                    // one step every second cycle, same in both directions
                    if (st_r.refc != st_r.goal)
                    begin
                        st_nxt.step_ph = ~st_r.step_ph;
                        if (st_r.step_ph)
                            st_nxt.refc = (st_r.refc < st_r.goal) ? st_r.refc + 5'h01
                                : st_r.refc - 5'h01;
                    end
                    else
                        st_nxt.step_ph = 1'b0;
                end
            end
        endcase
        // outputs; pwm released to high impedance whenever shut down
        st_nxt.pwm_oe = (st_nxt.state == VSS_SHUT) ? 2'b00 : 2'b11;
        st_nxt.pwm_out = pwm_s;
        st_nxt.osc_run = dis_n_s;
        st_nxt.pg_oe = !(st_nxt.state == VSS_RUN && win_s);
        st_nxt.target_mv = m_target;
        st_nxt.ramp_mv = m_ramp;
        st_nxt.iramp_ua = m_iramp;
        // apb: answer with zero wait states, pready raised for the access cycle
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = '0;
            unique case (paddr)
                VSS_CTRL_OFS:
                    st_nxt.prdata[VSS_CTRL_SOFT_EN_BIT] = st_r.soft_en;
                VSS_STATUS_OFS:
                begin
                    st_nxt.prdata[VSS_ST_STATE_LSB +: 2] = st_r.state;
                    st_nxt.prdata[VSS_ST_POWER_GOOD_FLAG_BIT] = ~st_r.pg_oe;
                    st_nxt.prdata[VSS_ST_PEND_BIT] = st_r.pend_v;
                    st_nxt.prdata[VSS_ST_OSC_BIT] = st_r.osc_run;
                end
                VSS_CODE_OFS:
                begin
                    st_nxt.prdata[VSS_CD_REF_LSB +: 5] = st_r.refc;
                    st_nxt.prdata[VSS_CD_GOAL_LSB +: 5] = st_r.goal;
                    st_nxt.prdata[VSS_CD_PEND_LSB +: 5] = st_r.pend;
                    st_nxt.prdata[VSS_CD_SAMP_LSB +: 5] = st_r.samp;
                end
                VSS_SSCNT_OFS:
                    st_nxt.prdata[10:0] = st_r.ss_cnt;
                VSS_LEVEL_OFS:
                begin
                    st_nxt.prdata[VSS_LV_TARGET_LSB +: 12] = st_r.target_mv;
                    st_nxt.prdata[VSS_LV_IRAMP_LSB +: 8] = st_r.iramp_ua;
                end
                default:
                    st_nxt.pslverr = 1'b1; // unmapped address
            endcase
        end
        if (psel && penable && st_r.pready && pwrite && !st_r.pslverr &&
            paddr == VSS_CTRL_OFS)
            st_nxt.soft_en = pwdata[VSS_CTRL_SOFT_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.state <= VSS_SHUT;
            st_r.samp <= VSS_CODE_RESET;
            st_r.goal <= VSS_CODE_RESET;
            st_r.refc <= VSS_CODE_RESET;
            st_r.soft_en <= VSS_CTRL_RESET[VSS_CTRL_SOFT_EN_BIT];
            st_r.pg_oe <= 1'b1; // power good held low through reset
        end
        else
            st_r <= st_nxt;
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pwm_out = st_r.pwm_out;
    assign pwm_oe = st_r.pwm_oe;
    assign power_good_flag_out = 1'b0; // open drain: only ever pulls low
    assign power_good_flag_oe = st_r.pg_oe;
    assign osc_run = st_r.osc_run;
    assign ref_code = st_r.refc;
    assign target_mv = st_r.target_mv;
    assign ramp_mv = st_r.ramp_mv;
    assign iramp_ua = st_r.iramp_ua;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pwm_release_a: assert property (st_r.state != VSS_SHUT && !start_ok |=> pwm_oe == 2'b00)
        else $error("pwm not released on shutdown");
    start_now_a: assert property (st_r.state == VSS_SHUT && start_ok
        |=> st_r.state == VSS_SOFT && st_r.ss_cnt == 11'h000)
        else $error("soft-start did not begin at once");
    ss_length_a: assert property (st_r.state == VSS_SOFT && start_ok && pulse
        && code_s != VSS_CODE_RSV && st_r.ss_cnt == VSS_SS_LAST |=> st_r.state == VSS_RUN)
        else $error("soft-start end missed");
    reserved_shut_a: assert property (st_r.state != VSS_SHUT && pulse && code_s == VSS_CODE_RSV
        |=> st_r.state == VSS_SHUT ##1 pwm_oe == 2'b00)
        else $error("reserved code did not shut down");
    sample_hold_a: assert property (!pulse |=> $stable(st_r.samp))
        else $error("code sampled between cycle starts");
    accept_code_a: assert property (st_r.state != VSS_SHUT && start_ok && pulse && st_r.pend_v
        && code_s == st_r.pend && code_s != VSS_CODE_RSV
        |=> st_r.goal == $past(st_r.pend) && !st_r.pend_v)
        else $error("validated code not accepted");
    one_step_a: assert property (st_r.state != VSS_SHUT && $past(st_r.state) != VSS_SHUT
        && st_r.refc != $past(st_r.refc)
        |-> $past(pulse) && $past(st_r.step_ph)
        && (st_r.refc == $past(st_r.refc) + 5'h01 || st_r.refc == $past(st_r.refc) - 5'h01))
        else $error("reference moved by other than one step");
    soft_min_a: assert property (st_r.state == VSS_SOFT ##1 st_r.state == VSS_SOFT
        |-> target_mv <= ramp_mv || target_mv == m_ref)
        else $error("target above ramp in soft-start");
    run_iramp_a: assert property (st_r.state == VSS_RUN |-> iramp_ua == 8'h00)
        else $error("offset current not zero after soft-start");
    pg_gate_a: assert property (st_r.state != VSS_RUN |-> power_good_flag_oe)
        else $error("power good released outside run");

    cv_soft_done_c: cover property (st_r.state == VSS_SOFT ##1 st_r.state == VSS_RUN);
    cv_step_c: cover property (st_r.state == VSS_RUN && st_r.refc != $past(st_r.refc));
    cv_restart_c: cover property (pulse && st_r.pend_v && code_s != st_r.pend
        && code_s != st_r.goal);
    cv_rsv_c: cover property (st_r.state == VSS_RUN ##1 st_r.state == VSS_SHUT);
endmodule

// >>> verification/vss_cpu_model.sv
`timescale 1ns/1ns
// processor side: drives the identification code and stands in for the phase oscillator
module vss_cpu_model #(
    parameter int PH = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_run,
    input wire logic [4:0] code_req,
    input wire logic glitch,
    output logic phase_clk,
    output logic [4:0] voltage_id_code
);
    int cnt;

    // code moves mid-cycle and at the last count, never on a phase clock edge, so the sampling pulse never races a pin change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            phase_clk <= 1'b0;
            voltage_id_code <= 5'h1f;
        end
        else
        begin
            cnt <= (cnt == PH - 1) ? 0 : cnt + 1;
            phase_clk <= osc_run && (cnt < 2);
            if (cnt == PH / 2)
                voltage_id_code <= code_req;
            else if (glitch && cnt == PH / 2 + 1)
                voltage_id_code <= ~code_req;
            else if (cnt == PH - 1)
                voltage_id_code <= code_req;
        end
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
    import vss_pkg::*;
    localparam int PH = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, power_good_flag_out, power_good_flag_oe, osc_run, phase_clk;
    logic por_ok = 0, enable_cmp = 0, freq_select_disable = 0, out_in_window = 0, glitch = 0;
    logic [1:0] pwm_mod = 2'b00, pwm_out, pwm_oe;
    logic [4:0] code_req = 5'h1f, voltage_id_code, ref_code;
    logic [11:0] target_mv, ramp_mv;
    logic [7:0] iramp_ua;
    int fail_count = 0, checked = 0, cyc = 0, pulses = 0, p0, t0, t1, t2, e;
    logic bad = 0;

    vss_sequencer u_vss_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .por_ok(por_ok), .enable_cmp(enable_cmp),
        .freq_select_disable(freq_select_disable), .phase_clk(phase_clk),
        .voltage_id_code(voltage_id_code), .out_in_window(out_in_window), .pwm_mod(pwm_mod),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .power_good_flag_out(power_good_flag_out),
        .power_good_flag_oe(power_good_flag_oe), .osc_run(osc_run), .ref_code(ref_code),
        .target_mv(target_mv), .ramp_mv(ramp_mv), .iramp_ua(iramp_ua));
    vss_cpu_model #(.PH(PH)) u_vss_cpu_model (.pclk(pclk), .presetn(presetn),
        .osc_run(osc_run), .code_req(code_req), .glitch(glitch), .phase_clk(phase_clk),
        .voltage_id_code(voltage_id_code));

    always #4 pclk = ~pclk;
    // pulse count lets soft-start length be judged in switching cycles
    always @(posedge phase_clk) pulses++;
    // cycle count doubles as the hang limit
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // polls status; the bound covers a whole soft-start
    task wait_state(input logic [1:0] s);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, VSS_STATUS_OFS, 32'h0);
            n++;
        end
        while (rd[VSS_ST_STATE_LSB +: 2] !== s && n < 9000);
        check(rd[VSS_ST_STATE_LSB +: 2], s);
    endtask

    task wait_ref(output int t);
        logic [4:0] r;
        int n;
        r = ref_code;
        n = 0;
        while (ref_code === r && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        t = cyc;
    endtask

    task drop(input int i, input logic v);
        case (i)
            0: por_ok <= v;
            1: enable_cmp <= v;
            2: freq_select_disable <= v;
            default: apb(1'b1, VSS_CTRL_OFS, {31'h0, v});
        endcase
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        check(pwm_oe, 2'b00);
        check(power_good_flag_oe, 1'b1);
        presetn <= 1'b1;
        apb(1'b0, VSS_CTRL_OFS, 32'h0);
        check(rd, VSS_CTRL_RESET);
        apb(1'b0, 12'h100, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        apb(1'b1, VSS_STATUS_OFS, 32'hffff_ffff);
        por_ok <= 1'b1;
        enable_cmp <= 1'b1;
        freq_select_disable <= 1'b1;
        repeat (4 * PH) @(posedge pclk);
        wait_state(VSS_SHUT);
        check(pwm_oe, 2'b00);
        code_req <= 5'h0a;
        wait_state(VSS_SOFT);
        repeat (2) @(posedge pclk);
        check(pwm_oe, 2'b11);
        // each start condition except the reserved-code check taken away and given back in turn
        for (int i = 0; i < 4; i++)
        begin
            drop(i, 1'b0);
            wait_state(VSS_SHUT);
            check(pwm_oe, 2'b00);
            check(osc_run, i != 2);
            drop(i, 1'b1);
            wait_state(VSS_SOFT);
            apb(1'b0, VSS_SSCNT_OFS, 32'h0);
            check(rd[10:0] < 11'd4, 1'b1);
            p0 = pulses - int'(rd[10:0]);
        end
        out_in_window <= 1'b1;
        repeat (1024 * PH) @(posedge pclk);
        apb(1'b0, VSS_SSCNT_OFS, 32'h0);
        e = int'(ramp_mv) - 1820 * int'(rd[10:0]) / 2048;
        check(e >= -4 && e <= 4, 1'b1);
        e = int'(iramp_ua) - (160 - 160 * int'(rd[10:0]) / 2048);
        check(e >= -2 && e <= 2, 1'b1);
        check(target_mv, ramp_mv);
        check(power_good_flag_oe, 1'b1);
        wait_state(VSS_RUN);
        check(pulses - p0 >= 2047 && pulses - p0 <= 2050, 1'b1);
        check({iramp_ua, ramp_mv, target_mv}, {8'h00, 12'd1820, 12'd1300});
        pwm_mod <= 2'b10;
        repeat (5) @(posedge pclk);
        check(power_good_flag_oe, 1'b0);
        check(power_good_flag_out, 1'b0);
        check(pwm_out, 2'b10);
        // upward walk, then downward walk with the same cadence
        t0 = cyc;
        code_req <= 5'h06;
        wait_ref(t1);
        check(t1 - t0 > PH, 1'b1);
        check(ref_code, 5'h09);
        wait_ref(t2);
        check(t2 - t1, 2 * PH);
        repeat (6 * PH) @(posedge pclk);
        check({ref_code, target_mv}, {5'h06, 12'd1400});
        code_req <= 5'h08;
        wait_ref(t1);
        check(ref_code, 5'h07);
        wait_ref(t2);
        check(ref_code, 5'h08);
        check(t2 - t1, 2 * PH);
        glitch <= 1'b1;
        repeat (6 * PH) @(posedge pclk);
        glitch <= 1'b0;
        check(ref_code, 5'h08);
        // a code abandoned in validation must not be approached
        code_req <= 5'h0c;
        // wait until a cycle start really catches the abandoned code on the pins
        while (!(phase_clk === 1'b1 && voltage_id_code === 5'h0c) && cyc < 59000)
            @(posedge pclk);
        code_req <= 5'h04;
        repeat (16 * PH)
        begin
            @(posedge pclk);
            if (ref_code > 5'h08)
                bad = 1'b1;
        end
        check({bad, ref_code}, {1'b0, 5'h04});
        code_req <= 5'h1f;
        wait_state(VSS_SHUT);
        check({pwm_oe, power_good_flag_oe}, 3'b001);
        code_req <= 5'h0a;
        wait_state(VSS_SOFT);
        print_verdict();
    end
endmodule
